// ---- core/itms_top.sv ----
// Trigger-mode select block: I/O port decode, registers, request gating
// Notes on behaviour
// - Low mode register bits 7..3 pick IRQ7..IRQ3; 0 edge, 1 level.
// - Port 4D1h bits 7,6,4,3,2,1 pick IRQ15,14,12,11,10,9 modes.
// - IRQ0, IRQ1, IRQ2, IRQ13 mode bits written zero, always read zero.
// - IRQ8 mode bit is written zero by software and always reads zero.
// - Reset clears both mode registers, every line starts edge-sensitive.
// - Ports 20h, 21h, A0h, A1h are read/write from PCI or ISA.
`timescale 1ns/1ps
module itms_top #(
  parameter int NUM_LINES = 16
) (
  input  wire logic        sys_clk,    // 50 MHz system clock
  input  wire logic        rst,        // Async reset, high
  input  wire logic        ce,         // Clock enable, freezes state
  input  wire logic        ioWr,       // I/O write strobe
  input  wire logic        ioRd,       // I/O read strobe
  input  wire logic        ioFromIsa,  // 1 = cycle came from ISA side
  input  wire logic [15:0] ioAddr,     // I/O port address
  input  wire logic [7:0]  ioWrData,   // Write data
  output logic             ioHit,      // Address claimed by this block
  output logic [7:0]       ioRdData,   // Read data, registered
  output logic             ioRdValid,  // Read data valid, one cycle
  input  wire logic [NUM_LINES-1:0] irqPin, // Raw request pins
  input  wire logic [NUM_LINES-1:0] irqAck, // Clears edge requests
  output logic [NUM_LINES-1:0] irqReq,  // Unmasked requests
  output logic [NUM_LINES-1:0] irqMode  // Per-line mode, 1 = level
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] primCmd;
    logic [7:0] primMask;
    logic [7:0] secCmd;
    logic [7:0] secMask;
    logic [7:0] modeLow;
    logic [7:0] modeHigh;
    logic [7:0] rdData;
    logic       rdValid;
  } itms_top_state_t;

  itms_top_state_t    st;
  itms_top_state_t    next_st;
  itms_pkg::itms_sel_t sel;
  logic [7:0]         readVal;
  logic [NUM_LINES-1:0] maskVec;

  itms_req_if #(.NUM_LINES(NUM_LINES)) rq ();

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  // PCI and ISA cycles share one decode; the source does not matter
  assign sel   = itms_pkg::itms_decode(ioAddr);
  assign ioHit = (ioWr | ioRd) && sel != itms_pkg::ITMS_SEL_NONE;

  // Read mux; fixed-edge bits are never stored, so they read zero
  always_comb begin
    case (sel)
      itms_pkg::ITMS_SEL_PRIM_CMD:   readVal = st.primCmd;
      itms_pkg::ITMS_SEL_PRIM_MASK:  readVal = st.primMask;
      itms_pkg::ITMS_SEL_SEC_CMD:    readVal = st.secCmd;
      itms_pkg::ITMS_SEL_SEC_MASK:   readVal = st.secMask;
      itms_pkg::ITMS_SEL_MODE_LOW:   readVal = st.modeLow;
      itms_pkg::ITMS_SEL_MODE_HIGH:  readVal = st.modeHigh;
      default:                       readVal = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  // Read returns the value before a write in the same cycle
  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.rdValid = ioRd && sel != itms_pkg::ITMS_SEL_NONE;
      if (ioRd) begin
        next_st.rdData = readVal;
      end
      if (ioWr) begin
        case (sel)
          itms_pkg::ITMS_SEL_PRIM_CMD:  next_st.primCmd  = ioWrData;
          itms_pkg::ITMS_SEL_PRIM_MASK: next_st.primMask = ioWrData;
          itms_pkg::ITMS_SEL_SEC_CMD:   next_st.secCmd   = ioWrData;
          itms_pkg::ITMS_SEL_SEC_MASK:  next_st.secMask  = ioWrData;
          // Dropping the fixed bits keeps IRQ0-2 edge whatever is written
          itms_pkg::ITMS_SEL_MODE_LOW: begin
            next_st.modeLow = ioWrData &
                              itms_pkg::ITMS_MODE_LOW_WMASK;
          end
          // IRQ8 and IRQ13 stay edge the same way
          itms_pkg::ITMS_SEL_MODE_HIGH: begin
            next_st.modeHigh = ioWrData &
                               itms_pkg::ITMS_MODE_HIGH_WMASK;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Register the state; reset puts every line in edge mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st.primCmd  <= itms_pkg::ITMS_CMD_RESET;
      st.primMask <= itms_pkg::ITMS_MASK_RESET;
      st.secCmd   <= itms_pkg::ITMS_CMD_RESET;
      st.secMask  <= itms_pkg::ITMS_MASK_RESET;
      st.modeLow  <= itms_pkg::ITMS_MODE_RESET;
      st.modeHigh <= itms_pkg::ITMS_MODE_RESET;
      st.rdData   <= 8'h00;
      st.rdValid  <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------
  // Request path
  // ---------------------------------------------------------------------
  // Mode and ack go to the stage; masks gate only the outputs, so a
  // masked edge stays latched and shows once unmasked
  assign rq.mode  = NUM_LINES'({st.modeHigh, st.modeLow});
  assign rq.ack   = irqAck;
  assign maskVec  = NUM_LINES'({st.secMask, st.primMask});
  assign irqReq   = rq.req & ~maskVec;
  assign irqMode  = rq.mode;
  assign ioRdData = st.rdData;
  assign ioRdValid = st.rdValid;

  itms_req_stage #(
    .NUM_LINES (NUM_LINES)
  ) u_stage (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .irqPin  (irqPin),
    .rq      (rq)
  );

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_LOW_WRITE:
  assert property (ce && ioWr && ioAddr == itms_pkg::ITMS_ADDR_MODE_LOW |=>
                   st.modeLow == ($past(ioWrData) & 8'hf8))
    else $error("Low mode register did not take the written value");

  AST_HIGH_WRITE:
  assert property (ce && ioWr && ioAddr == itms_pkg::ITMS_ADDR_MODE_HIGH
                   |=> st.modeHigh == ($past(ioWrData) & 8'hde))
    else $error("High mode register did not take the written value");

  AST_FIXED_LOW_ZERO:
  assert property (ce && ioRd && ioAddr == itms_pkg::ITMS_ADDR_MODE_LOW |=>
                   ioRdValid && ioRdData[2:0] == 3'h0 &&
                   irqMode[2:0] == 3'h0 && irqMode[13] == 1'b0)
    else $error("Fixed-edge bit for IRQ0-2 or IRQ13 not zero");

  AST_IRQ8_ZERO:
  assert property (ce && ioRd && ioAddr == itms_pkg::ITMS_ADDR_MODE_HIGH
                   |=> ioRdValid && ioRdData[0] == 1'b0 &&
                   ioRdData[5] == 1'b0 && irqMode[8] == 1'b0)
    else $error("IRQ8 mode bit read back non-zero");

  AST_RESET_EDGE:
  assert property (disable iff (1'b0)
                   rst |=> (rst || (st.modeLow == 8'h00 &&
                            st.modeHigh == 8'h00)) ##0
                   (rst || irqMode == '0))
    else $error("Mode registers not cleared by reset");

  AST_MASK_RW:
  assert property (ce && ioWr && ioAddr == itms_pkg::ITMS_ADDR_SEC_MASK
                   ##1 !ioWr ##1 ce && ioRd && !ioWr &&
                   ioAddr == itms_pkg::ITMS_ADDR_SEC_MASK
                   |=> ioRdValid && ioRdData == $past(ioWrData, 3))
    else $error("Mask port did not read back its written value");

  AST_ISA_ACCEPT:
  assert property (ce && ioFromIsa && ioWr &&
                   ioAddr == itms_pkg::ITMS_ADDR_PRIM_CMD
                   |-> ioHit ##1 st.primCmd == $past(ioWrData))
    else $error("ISA write to command port not accepted");

  // A mask bit written through the port must silence that output
  AST_MASK_GATES:
  assert property (ce && ioWr && ioAddr == itms_pkg::ITMS_ADDR_PRIM_MASK
                   |=> (irqReq[7:0] & $past(ioWrData)) == 8'h00)
    else $error("Request output not gated by mask");

  // Unmasked level lines show the filtered input level
  AST_LEVEL_OUT:
  assert property (((irqReq ^ rq.line) & irqMode & ~maskVec) == '0)
    else $error("Level-mode output differs from its filtered input");

  COV_LEVEL_SET:  cover property (ce && ioWr &&
                   ioAddr == itms_pkg::ITMS_ADDR_MODE_LOW && ioWrData != 8'h00);
  COV_HIGH_READ:  cover property (ioRdValid && ioRdData != 8'h00);
  COV_ISA_MASK:   cover property (ce && ioFromIsa && ioWr &&
                   ioAddr == itms_pkg::ITMS_ADDR_PRIM_MASK);

endmodule : itms_top

// ---- pkg/itms_pkg.sv ----
// Package: port map, field masks and reset values of the trigger block
package itms_pkg;

  // ---------------------------------------------------------------------
  // I/O port addresses
  // ---------------------------------------------------------------------
  localparam logic [15:0] ITMS_ADDR_PRIM_CMD  = 16'h0020;
  localparam logic [15:0] ITMS_ADDR_PRIM_MASK = 16'h0021;
  localparam logic [15:0] ITMS_ADDR_SEC_CMD   = 16'h00a0;
  localparam logic [15:0] ITMS_ADDR_SEC_MASK  = 16'h00a1;
  localparam logic [15:0] ITMS_ADDR_MODE_LOW  = 16'h04d0;
  localparam logic [15:0] ITMS_ADDR_MODE_HIGH = 16'h04d1;

  // ---------------------------------------------------------------------
  // Writable bits of the two trigger-mode registers
  // ---------------------------------------------------------------------
  localparam logic [7:0] ITMS_MODE_LOW_WMASK  = 8'hf8; // IRQ7..IRQ3
  localparam logic [7:0] ITMS_MODE_HIGH_WMASK = 8'hde; // 15,14,12,11,10,9

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] ITMS_MODE_RESET = 8'h00; // All lines edge
  localparam logic [7:0] ITMS_CMD_RESET  = 8'h00;
  localparam logic [7:0] ITMS_MASK_RESET = 8'h00;

  // Register selected by a port address
  typedef enum logic [2:0] {
    ITMS_SEL_NONE,
    ITMS_SEL_PRIM_CMD,
    ITMS_SEL_PRIM_MASK,
    ITMS_SEL_SEC_CMD,
    ITMS_SEL_SEC_MASK,
    ITMS_SEL_MODE_LOW,
    ITMS_SEL_MODE_HIGH
  } itms_sel_t;

  // Port decode, shared by write and read paths
  function automatic itms_sel_t itms_decode(input logic [15:0] addr);
    case (addr)
      ITMS_ADDR_PRIM_CMD:  itms_decode = ITMS_SEL_PRIM_CMD;
      ITMS_ADDR_PRIM_MASK: itms_decode = ITMS_SEL_PRIM_MASK;
      ITMS_ADDR_SEC_CMD:   itms_decode = ITMS_SEL_SEC_CMD;
      ITMS_ADDR_SEC_MASK:  itms_decode = ITMS_SEL_SEC_MASK;
      ITMS_ADDR_MODE_LOW:  itms_decode = ITMS_SEL_MODE_LOW;
      ITMS_ADDR_MODE_HIGH: itms_decode = ITMS_SEL_MODE_HIGH;
      default:             itms_decode = ITMS_SEL_NONE;
    endcase
  endfunction : itms_decode

endpackage : itms_pkg

// ---- pkg/itms_req_if.sv ----
// Interface: trigger modes and request lines between control and stage
`timescale 1ns/1ps
interface itms_req_if #(
  parameter int NUM_LINES = 16
);
  logic [NUM_LINES-1:0] mode; // 1 = level, 0 = edge per line
  logic [NUM_LINES-1:0] ack;  // Clears a latched edge request
  logic [NUM_LINES-1:0] req;  // Request presented per line
  logic [NUM_LINES-1:0] line; // Filtered input level per line

  modport ctrl  (output mode, output ack, input req, input line);
  modport stage (input mode, input ack, output req, output line);
endinterface : itms_req_if

// ---- core/itms_req_stage.sv ----
// Request stage: pin synchroniser, filter and edge/level capture
`timescale 1ns/1ps
module itms_req_stage #(
  parameter int NUM_LINES = 16
) (
  input  wire logic           sys_clk,  // 50 MHz system clock
  input  wire logic           rst,      // Async reset, high
  input  wire logic           ce,       // Clock enable, freezes state
  input  wire logic [NUM_LINES-1:0] irqPin, // Raw request pins
  itms_req_if.stage           rq        // Modes in, requests out
);

  typedef struct packed {
    logic [NUM_LINES-1:0] s1;   // Meta stage, read by s2 only
    logic [NUM_LINES-1:0] s2;
    logic [NUM_LINES-1:0] s3;
    logic [NUM_LINES-1:0] filt; // Level once s2 and s3 agree
    logic [NUM_LINES-1:0] pend; // Latched edge requests
  } itms_stage_state_t;

  itms_stage_state_t st;
  itms_stage_state_t next_st;
  logic [NUM_LINES-1:0] agree;
  logic [NUM_LINES-1:0] rise;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  // A glitch shorter than one clock never reaches filt
  always_comb begin
    next_st = st;
    agree   = ~(st.s2 ^ st.s3);
    rise    = agree & st.s3 & ~st.filt;
    if (ce) begin
      next_st.s1   = irqPin;
      next_st.s2   = st.s1;
      next_st.s3   = st.s2;
      next_st.filt = (agree & st.s3) | (~agree & st.filt);
      // Edge lines latch on rise only; set beats a same-cycle ack
      next_st.pend = ~rq.mode & (rise | (st.pend & ~rq.ack));
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Level lines follow the input, edge lines show the latch
  assign rq.req  = (rq.mode & st.filt) | (~rq.mode & st.pend);
  assign rq.line = st.filt;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // A settled synchroniser value must show on level lines one edge later
  AST_LEVEL_FOLLOWS:
  assert property (ce |=> ((rq.req ^ $past(st.s3)) & rq.mode &
                           $past(agree)) == '0)
    else $error("Level-mode request does not follow its input");

  AST_EDGE_LATCH:
  assert property (ce && (rise & ~rq.mode) != '0 |=>
                   (rq.req & $past(rise & ~rq.mode)) == $past(rise & ~rq.mode))
    else $error("Edge-mode rise was not latched as a request");

  AST_EDGE_NO_SPURIOUS:
  assert property (ce && $stable(rq.mode) && rise == '0 |=>
                   (st.pend & ~$past(st.pend)) == '0)
    else $error("Edge request appeared without a rising input");

  COV_LEVEL_REQ: cover property ((rq.mode & rq.req) != '0);
  COV_EDGE_REQ:  cover property ((~rq.mode & rq.req) != '0);

endmodule : itms_req_stage

// ---- verif/itms_host_model.sv ----
// Host model: issues I/O port write and read cycles toward the block
`timescale 1ns/1ps
module itms_host_model (
  input  wire logic        sys_clk,   // System clock
  input  wire logic        ioHit,     // Claim from block
  input  wire logic [7:0]  ioRdData,  // Read data from block
  input  wire logic        ioRdValid, // Read data valid
  output logic             ioWr,      // Write strobe
  output logic             ioRd,      // Read strobe
  output logic             ioFromIsa, // Cycle source, 1 = ISA
  output logic [15:0]      ioAddr,    // Port address
  output logic [7:0]       ioWrData   // Write data
);
  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  initial begin
    ioWr      = 1'b0;
    ioRd      = 1'b0;
    ioFromIsa = 1'b0;
    ioAddr    = 16'hffff;
    ioWrData  = 8'h00;
  end

  // Released lines show the inverse so stale values never match
  task automatic io_write(input logic [15:0] a, input logic [7:0] d,
                          input logic isa);
    @(posedge sys_clk);
    ioWr      <= 1'b1;
    ioAddr    <= a;
    ioWrData  <= d;
    ioFromIsa <= isa;
    @(posedge sys_clk);
    ioWr     <= 1'b0;
    ioAddr   <= ~a;
    ioWrData <= ~d;
  endtask : io_write

  // Claim sampled 1 ns after the strobe goes out, data 1 ns after the taking edge
  task automatic io_read(input logic [15:0] a, input logic isa,
                         output logic hit, output logic [7:0] d,
                         output logic vld);
    @(posedge sys_clk);
    ioRd      <= 1'b1;
    ioAddr    <= a;
    ioFromIsa <= isa;
    #1 hit = ioHit;
    @(posedge sys_clk);
    ioRd   <= 1'b0;
    ioAddr <= ~a;
    #1 d = ioRdData;
    vld = ioRdValid;
  endtask : io_read
endmodule : itms_host_model

// ---- verif/irq_trigger_mode_select_test.sv ----
// Testbench: trigger-mode registers, controller ports and request path
`timescale 1ns/1ps
module irq_trigger_mode_select_test;
  logic        sys_clk, rst, ce, ioWr, ioRd, ioFromIsa, ioHit, ioRdValid;
  logic [15:0] ioAddr, irqPin, irqAck, irqReq, irqMode;
  logic [7:0]  ioWrData, ioRdData, rdData;
  logic        hit, vld;
  int          n_mismatch, checks, cycles;

  itms_top #(.NUM_LINES(16)) dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .ioWr(ioWr), .ioRd(ioRd), .ioFromIsa(ioFromIsa), .ioAddr(ioAddr),
    .ioWrData(ioWrData), .ioHit(ioHit), .ioRdData(ioRdData),
    .ioRdValid(ioRdValid), .irqPin(irqPin), .irqAck(irqAck),
    .irqReq(irqReq), .irqMode(irqMode));
  itms_host_model host (.sys_clk(sys_clk), .ioHit(ioHit),
    .ioRdData(ioRdData), .ioRdValid(ioRdValid), .ioWr(ioWr), .ioRd(ioRd),
    .ioFromIsa(ioFromIsa), .ioAddr(ioAddr), .ioWrData(ioWrData));

  // ---------------------------------------------------------------
  // Clock, timeout and reporting
  // ---------------------------------------------------------------
  always #10 sys_clk = ~sys_clk;

  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_cycles

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    host.io_read(pkg_low(), 1'b0, hit, rdData, vld);
    check("mode low reset", {8'h00, rdData}, 16'h0000);
    host.io_read(16'h04d1, 1'b1, hit, rdData, vld);
    check("mode high reset", {8'h00, rdData}, 16'h0000);
    check("irqMode reset", irqMode, 16'h0000);
    $display("test reset done");
  endtask : test_reset

  function automatic logic [15:0] pkg_low();
    return itms_pkg::ITMS_ADDR_MODE_LOW;
  endfunction : pkg_low

  // All ones written: fixed bits must stay zero
  task automatic test_mode_regs();
    host.io_write(pkg_low(), 8'hff, 1'b0);
    host.io_read(pkg_low(), 1'b1, hit, rdData, vld);
    check("mode low read", {7'h00, vld, rdData}, 16'h01f8);
    check("mode low fixed", {8'h00, rdData & 8'h07}, 16'h0000);
    host.io_write(16'h04d1, 8'hff, 1'b1);
    host.io_read(16'h04d1, 1'b0, hit, rdData, vld);
    check("mode high read", {8'h00, rdData}, 16'h00de);
    check("mode high irq13", {15'h0000, rdData[5]}, 16'h0000);
    check("mode high irq8", {15'h0000, rdData[0]}, 16'h0000);
    check("irqMode all", irqMode, 16'hdef8);
    host.io_write(16'h04d1, 8'h00, 1'b0);
    host.io_write(pkg_low(), 8'h08, 1'b0);
    wait_cycles(1);
    check("irqMode line3", irqMode, 16'h0008);
    $display("test mode registers done");
  endtask : test_mode_regs

  // Each controller port from both sides, then an unmapped port
  task automatic test_pic_ports();
    logic [15:0] ports [4];
    logic [7:0]  vals  [4];
    ports = '{16'h0020, 16'h0021, 16'h00a0, 16'h00a1};
    vals  = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
    for (int i = 0; i < 4; i++) begin
      host.io_write(ports[i], vals[i], ~i[0]);
      host.io_read(ports[i], i[0], hit, rdData, vld);
      check("port rw", {6'h00, hit, vld, rdData}, {8'h03, vals[i]});
    end
    host.io_read(16'h0022, 1'b0, hit, rdData, vld);
    check("unmapped claim", {14'h0000, hit, vld}, 16'h0000);
    host.io_write(16'h0021, 8'h00, 1'b0);
    host.io_write(16'h00a1, 8'h00, 1'b1);
    $display("test controller ports done");
  endtask : test_pic_ports

  // Line 3 in level mode follows its pin
  task automatic test_level_line();
    @(posedge sys_clk);
    irqPin <= 16'h0008;
    wait_cycles(6);
    check("level held", irqReq, 16'h0008);
    wait_cycles(4);
    check("level still", irqReq, 16'h0008);
    @(posedge sys_clk);
    irqPin <= 16'h0000;
    wait_cycles(6);
    check("level gone", irqReq, 16'h0000);
    $display("test level line done");
  endtask : test_level_line

  // Line 4 in edge mode latches a short pulse until acknowledged
  task automatic test_edge_line();
    @(posedge sys_clk);
    irqPin <= 16'h0010;
    wait_cycles(3);
    @(posedge sys_clk);
    irqPin <= 16'h0000;
    wait_cycles(6);
    check("edge latched", irqReq, 16'h0010);
    host.io_write(16'h0021, 8'h10, 1'b0);
    wait_cycles(1);
    check("edge masked", irqReq, 16'h0000);
    host.io_write(16'h0021, 8'h00, 1'b1);
    wait_cycles(1);
    check("edge unmasked", irqReq, 16'h0010);
    @(posedge sys_clk);
    irqAck <= 16'h0010;
    @(posedge sys_clk);
    irqAck <= 16'h0000;
    wait_cycles(1);
    check("edge cleared", irqReq, 16'h0000);
    $display("test edge line done");
  endtask : test_edge_line

  // Writes with the enable low are dropped; a mid-run reset clears modes
  task automatic test_ce_reset();
    host.io_write(pkg_low(), 8'hf8, 1'b0);
    @(posedge sys_clk);
    ce <= 1'b0;
    host.io_write(16'h04d1, 8'hde, 1'b0);
    @(posedge sys_clk);
    ce <= 1'b1;
    host.io_read(16'h04d1, 1'b0, hit, rdData, vld);
    check("ce low write", {8'h00, rdData}, 16'h0000);
    check("irqMode before reset", irqMode, 16'h00f8);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    host.io_read(pkg_low(), 1'b0, hit, rdData, vld);
    check("mode low after reset", {8'h00, rdData}, 16'h0000);
    check("irqMode after reset", irqMode, 16'h0000);
    $display("test enable and reset done");
  endtask : test_ce_reset

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk    = 1'b0;
    rst        = 1'b1;
    ce         = 1'b1;
    irqPin     = 16'h0000;
    irqAck     = 16'h0000;
    n_mismatch = 0;
    checks     = 0;
    cycles     = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_mode_regs();
    test_pic_ports();
    test_level_line();
    test_edge_line();
    test_ce_reset();
    give_verdict();
  end
endmodule : irq_trigger_mode_select_test
